// ===== conv_fifo_dev.sv
// Device end: 256-entry conversion buffer with serial readback.
// Assumes conversions arrive as one-cycle pulses on the core clock and
// the host leaves a lead time after select before clocking.
`default_nettype none

// Function
// - Streaming keeps storing past watermark, unread.
// - Full streaming buffer overwrites oldest entry.
// - Streaming read anytime except during a write.
// - Overwrite in streaming sets overrun status.
// - Watermark full drops results, contents unchanged.
// - Control register fields and reset 0x040200.
// - Readback starts with command byte 0x7D.
// - Count byte follows; zero means 256.
// - Entries shift out on serial data out.
// - Last entry read sets empty header, status.
// - Reads past empty return zeros, empty set.
// - Readback ends on select high or count.
// - Header by default; status byte when enabled.
// - Command and count take 16 clocks.
// - Sample 24 or 32 clocks by header.
// - No buffer writes while link owns buffer.
// - Host finishes within two conversions minus eight.
// - Mode zero disables, clears buffer; default.
// - Entry is header byte plus 24-bit result.
// - Watermark zero means 256 samples.
// - Delay write one conversion, then write error.
module conv_fifo_dev (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_conv_valid,
  input  wire logic [23:0] i_conv_data,
  input  wire logic [3:0]  i_conv_chan,
  spi_link_if.dev          link,
  output logic             o_own,
  output logic      [8:0]  o_count,
  output logic      [7:0]  o_status,
  output logic      [23:0] o_ctrl
);

  // ----------------------------------------------------------------
  // Core clock domain: buffer, pointers, flags
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] ctrl;
    logic [7:0]  rd;
    logic [7:0]  wr;
    logic [8:0]  cnt;
    logic [8:0]  pk;
    logic        pend;
    logic [31:0] pend_w;
    logic        empty;
    logic        ovr;
    logic        werr;
    logic        rerr;
    logic        zero;
    logic        own;
    logic        take;
    logic        done;
    logic        wreq;
    logic        pub;
    logic [7:0]  sts;
    logic [63:0] hold;
  } core_t;

  typedef enum logic [5:0] {
    L_CMD  = 6'h01,
    L_CNT  = 6'h02,
    L_SAMP = 6'h04,
    L_RREG = 6'h08,
    L_WREG = 6'h10,
    L_IDLE = 6'h20
  } lph_t;

  typedef struct packed {
    lph_t        ph;
    logic [4:0]  bc;
    logic [23:0] ib;
    logic [31:0] ob;
    logic [8:0]  left;
    logic        hdr;
  } lframe_t;

  typedef struct packed {
    logic        take;
    logic        done;
    logic        wreq;
    logic [23:0] wdat;
  } ltog_t;

  core_t       q, n;
  lframe_t     lf_q, lf_d;
  ltog_t       lt_q, lt_d;
  logic [31:0] mem [rfifo_pkg::DEPTH];
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_word;
  logic [3:0]  c_sync;
  logic        pub_s;
  logic        lrst;

  // Select, and the three link toggles, brought into the core clock
  sync2 #(.W(4), .RST(4'h1)) u_core_sync (
    .i_clk (i_core_clk),
    .i_rst (i_rst),
    .i_d   ({lt_q.wreq, lt_q.done, lt_q.take, link.cs_n}),
    .o_q   (c_sync)
  );

  // Core state update, written as ordered steps in one pass
  always_comb begin
    logic [8:0]  lvl;
    logic [1:0]  mode;
    logic        mode_on;
    logic        do_wr;
    logic        pubnow;
    logic [31:0] w;
    logic [31:0] ent;
    logic [7:0]  idx;
    lvl     = 9'h000;
    mode    = q.ctrl[rfifo_pkg::CTRL_MODE_LSB +: 2];
    mode_on = 1'b0;
    do_wr   = 1'b0;
    pubnow  = 1'b0;
    w       = 32'h00000000;
    ent     = 32'h00000000;
    idx     = 8'h00;
    n       = q;
    wr_en   = 1'b0;
    wr_addr = q.wr;
    wr_word = 32'h00000000;
    mode_on = (mode == rfifo_pkg::MODE_WM) ||
              (mode == rfifo_pkg::MODE_STREAM);
    lvl = (q.ctrl[7:0] == 8'h00) ? 9'h100 : {1'b0, q.ctrl[7:0]};
    n.own  = ~c_sync[0];
    n.take = c_sync[1];
    n.done = c_sync[2];
    n.wreq = c_sync[3];
    if (c_sync[3] != q.wreq) begin
      n.ctrl = lt_q.wdat;
    end
    // Fully shifted sample retires; a partial one never gets here
    if (c_sync[2] != q.done && n.cnt != 9'h000) begin
      n.rd  = n.rd + 8'h01;
      n.cnt = n.cnt - 9'h001;
      if (n.pk != 9'h000) begin
        n.pk = n.pk - 9'h001;
      end
      if (n.cnt == 9'h000) begin
        n.ovr   = 1'b0;
        n.werr  = 1'b0;
        n.rerr  = 1'b0;
        n.empty = 1'b1;
      end
    end
    // Pending result goes in once the link lets go of the buffer
    if (!q.own && q.pend) begin
      do_wr  = 1'b1;
      w      = q.pend_w;
      n.pend = 1'b0;
    end
    if (i_conv_valid && mode_on) begin
      if (q.own || do_wr) begin
        if (n.pend) begin
          n.werr = 1'b1;
        end
        n.pend   = 1'b1;
        n.pend_w = {4'h0, i_conv_chan, i_conv_data};
      end else begin
        do_wr = 1'b1;
        w     = {4'h0, i_conv_chan, i_conv_data};
      end
    end
    if (do_wr) begin
      w[24 + rfifo_pkg::HDR_WM_BIT] =
        ({1'b0, q.cnt} + 10'h001) >= {1'b0, lvl};
      wr_word = w;
      n.empty = 1'b0;
      if (mode == rfifo_pkg::MODE_STREAM && q.cnt == 9'h100) begin
        wr_en = 1'b1;
        n.wr  = n.wr + 8'h01;
        n.rd  = n.rd + 8'h01;
        n.ovr = 1'b1;
      end else if (mode == rfifo_pkg::MODE_WM && q.cnt >= lvl) begin
        n.ovr  = 1'b1;
        n.werr = 1'b1;
      end else begin
        wr_en = 1'b1;
        n.wr  = n.wr + 8'h01;
        n.cnt = n.cnt + 9'h001;
      end
    end
    // Link takes the buffer; a write in this very cycle spoils the read
    if (!q.own && !c_sync[0]) begin
      n.pk   = 9'h000;
      n.zero = do_wr;
      n.rerr = do_wr ? 1'b1 : 1'b0;
      pubnow = 1'b1;
    end
    if (c_sync[1] != q.take) begin
      n.pk   = n.pk + 9'h001;
      n.pub  = c_sync[1];
      pubnow = 1'b1;
    end
    if (!mode_on) begin
      n.rd    = 8'h00;
      n.wr    = 8'h00;
      n.cnt   = 9'h000;
      n.pk    = 9'h000;
      n.pend  = 1'b0;
      n.ovr   = 1'b0;
      n.werr  = 1'b0;
      n.rerr  = 1'b0;
      n.empty = 1'b1;
    end
    // Present the entry at the peek position together with status
    if (pubnow) begin
      idx = n.rd + n.pk[7:0];
      if (n.zero) begin
        ent = 32'h00000000;
      end else if (n.pk >= n.cnt) begin
        ent     = 32'h10000000;
        n.empty = 1'b1;
      end else begin
        ent = mem[idx];
        if (n.pk + 9'h001 == n.cnt) begin
          ent[24 + rfifo_pkg::HDR_EMPTY_BIT] = 1'b1;
          n.empty = 1'b1;
        end
      end
    end
    n.sts = {1'b0, n.werr, n.rerr, 2'b00, n.ovr,
             (n.cnt >= lvl), n.empty};
    if (pubnow) begin
      n.hold = {n.ctrl, n.sts, ent};
    end
  end

  // Core state register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q       <= '0;
      q.ctrl  <= rfifo_pkg::CTRL_RST;
      q.empty <= 1'b1;
      q.sts   <= rfifo_pkg::STS_RST;
      q.take  <= 1'b0;
      q.own   <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // Entry storage has no reset; stale words are never presented
  always_ff @(posedge i_core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_word;
    end
  end

  assign o_own    = q.own;
  assign o_count  = q.cnt;
  assign o_status = q.sts;
  assign o_ctrl   = q.ctrl;

  // ----------------------------------------------------------------
  // Link clock domain: command decode and bit shifting
  // ----------------------------------------------------------------
  sync2 #(.W(1), .RST(1'b0)) u_link_sync (
    .i_clk (link.sclk),
    .i_rst (i_rst),
    .i_d   (q.pub),
    .o_q   (pub_s)
  );

  // Frame state clears while select is high; the clock stops then
  assign lrst = i_rst | link.cs_n;

  // Hold word is read only while the echo matches our last request
  always_comb begin
    logic        rdy;
    logic [23:0] inb;
    logic [31:0] ent;
    logic [4:0]  last_bc;
    rdy     = (pub_s == lt_q.take);
    inb     = {lf_q.ib[22:0], link.sdi};
    ent     = lf_q.hdr ? q.hold[31:0] : {q.hold[23:0], 8'h00};
    last_bc = lf_q.hdr ? 5'h1F : 5'h17;
    lf_d    = lf_q;
    lt_d    = lt_q;
    lf_d.ib = inb;
    lf_d.ob = {lf_q.ob[30:0], 1'b0};
    lf_d.bc = lf_q.bc + 5'h01;
    unique case (lf_q.ph)
      L_CMD: begin
        if (lf_q.bc == 5'h07) begin
          lf_d.bc = 5'h00;
          if (inb[7:0] == rfifo_pkg::CMD_FIFO_RD) begin
            lf_d.ph  = L_CNT;
            lf_d.hdr = rdy ? q.hold[40 + rfifo_pkg::CTRL_HDR_BIT] : 1'b1;
            if (rdy && q.hold[40 + rfifo_pkg::CTRL_STS_BIT]) begin
              lf_d.ob = {q.hold[39:32], 24'h000000};
            end
          end else if (inb[7:0] == rfifo_pkg::CMD_CTRL_RD) begin
            lf_d.ph = L_RREG;
            lf_d.ob = rdy ? {q.hold[63:40], 8'h00} : 32'h00000000;
          end else if (inb[7:0] == rfifo_pkg::CMD_CTRL_WR) begin
            lf_d.ph = L_WREG;
          end else begin
            lf_d.ph = L_IDLE;
          end
        end
      end
      L_CNT: begin
        if (lf_q.bc == 5'h07) begin
          lf_d.bc   = 5'h00;
          lf_d.ph   = L_SAMP;
          lf_d.left = (inb[7:0] == 8'h00) ? 9'h100 : {1'b0, inb[7:0]};
          lf_d.ob   = rdy ? ent : 32'h00000000;
          lt_d.take = ~lt_q.take;
        end
      end
      L_SAMP: begin
        if (lf_q.bc == last_bc) begin
          lf_d.bc   = 5'h00;
          lf_d.left = lf_q.left - 9'h001;
          lt_d.done = ~lt_q.done;
          if (lf_q.left == 9'h001) begin
            lf_d.ph = L_IDLE;
          end else begin
            lf_d.ob   = rdy ? ent : 32'h00000000;
            lt_d.take = ~lt_q.take;
          end
        end
      end
      L_WREG: begin
        if (lf_q.bc == 5'h17) begin
          lt_d.wdat = inb;
          lt_d.wreq = ~lt_q.wreq;
          lf_d.ph   = L_IDLE;
        end
      end
      L_RREG, L_IDLE: begin
        lf_d.bc = lf_q.bc;
      end
    endcase
  end

  // Per-frame link state
  always_ff @(posedge link.sclk or posedge lrst) begin
    if (lrst) begin
      lf_q    <= '0;
      lf_q.ph <= L_CMD;
    end else begin
      lf_q <= lf_d;
    end
  end

  // Toggles must keep their parity across frames
  always_ff @(posedge link.sclk or posedge i_rst) begin
    if (i_rst) begin
      lt_q      <= '0;
      lt_q.wdat <= rfifo_pkg::CTRL_RST;
    end else begin
      lt_q <= lt_d;
    end
  end

  assign link.sdo = lf_q.ob[31];

endmodule

`default_nettype wire

// ===== conv_fifo_host.sv
// Host end: frames readback and control register accesses on the link.
// Assumes the user tells it the header and status append settings.
`default_nettype none

module conv_fifo_host #(
  parameter int HALF         = 3,
  parameter int LEAD_CYC     = 8,
  parameter int CONV_TIME_NS = 416667,
  parameter int BUDGET_CYC   = (2 * CONV_TIME_NS) /
                               rfifo_pkg::CORE_PERIOD_NS -
                               rfifo_pkg::BUSY_QUIET_MCLK
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic [1:0]  i_op,
  input  wire logic [7:0]  i_count,
  input  wire logic [23:0] i_wdata,
  input  wire logic        i_hdr_en,
  input  wire logic        i_sts_en,
  spi_link_if.host         link,
  output logic             o_busy,
  output logic             o_word_valid,
  output logic      [31:0] o_word,
  output logic             o_status_valid,
  output logic      [7:0]  o_status,
  output logic             o_rdata_valid,
  output logic      [23:0] o_rdata,
  output logic             o_done,
  output logic             o_late
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (HALF < 3 || HALF > 127) begin : g_bad_half
    $error("HALF must lie in 3..127");
  end
  if (LEAD_CYC < 4 || LEAD_CYC > 255) begin : g_bad_lead
    $error("LEAD_CYC must lie in 4..255");
  end
  if (BUDGET_CYC < 1 || BUDGET_CYC > 16777215) begin : g_bad_budget
    $error("BUDGET_CYC out of range");
  end

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_LEAD  = 4'h2,
    H_SHIFT = 4'h4,
    H_TAIL  = 4'h8
  } hst_t;

  typedef struct packed {
    hst_t        st;
    logic [7:0]  ph;
    logic [13:0] bn;
    logic [13:0] last;
    logic [5:0]  sc;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [1:0]  op;
    logic        hdr;
    logic        sts;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        busy;
    logic        wv;
    logic [31:0] word;
    logic        sv;
    logic [7:0]  status;
    logic        rv;
    logic [23:0] rdata;
    logic        done;
    logic        late;
    logic [23:0] tm;
  } host_t;

  host_t q, n;
  logic  sdo_s;

  // Data out is a pin from the far side
  sync2 #(.W(1), .RST(1'b0)) u_sdo_sync (
    .i_clk (i_core_clk),
    .i_rst (i_rst),
    .i_d   (link.sdo),
    .o_q   (sdo_s)
  );

  // ----------------------------------------------------------------
  // Frame sequencer; the link clock is a divided core clock
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rxb;
    logic [5:0]  slen;
    int          nsamp;
    rxb   = {q.rx[30:0], sdo_s};
    slen  = q.hdr ? 6'(rfifo_pkg::SAMP_BITS_HDR) :
                    6'(rfifo_pkg::SAMP_BITS_RAW);
    nsamp = (i_count == 8'h00) ? 256 : int'(i_count);
    n      = q;
    n.wv   = 1'b0;
    n.sv   = 1'b0;
    n.rv   = 1'b0;
    n.done = 1'b0;
    // Readback must end inside the conversion budget
    if (q.busy && q.tm != 24'hFFFFFF) begin
      n.tm = q.tm + 24'h000001;
    end
    if (q.busy && q.tm >= 24'(BUDGET_CYC)) begin
      n.late = 1'b1;
    end
    unique case (q.st)
      H_IDLE: begin
        if (i_start) begin
          n.st   = H_LEAD;
          n.busy = 1'b1;
          n.cs_n = 1'b0;
          n.ph   = 8'h00;
          n.bn   = 14'h0000;
          n.sc   = 6'h00;
          n.tm   = 24'h000000;
          n.late = 1'b0;
          n.op   = i_op;
          n.hdr  = i_hdr_en;
          n.sts  = i_sts_en;
          if (i_op == rfifo_pkg::OP_FIFO) begin
            n.tx   = {rfifo_pkg::CMD_FIFO_RD, i_count, 16'h0000};
            n.last = 14'(rfifo_pkg::CMD_BITS - 1 + nsamp *
                         (i_hdr_en ? rfifo_pkg::SAMP_BITS_HDR :
                                     rfifo_pkg::SAMP_BITS_RAW));
          end else if (i_op == rfifo_pkg::OP_RREG) begin
            n.tx   = {rfifo_pkg::CMD_CTRL_RD, 24'h000000};
            n.last = 14'(8 + rfifo_pkg::REG_BITS - 1);
          end else begin
            n.tx   = {rfifo_pkg::CMD_CTRL_WR, i_wdata};
            n.last = 14'(8 + rfifo_pkg::REG_BITS - 1);
          end
        end
      end
      H_LEAD: begin
        n.ph = q.ph + 8'h01;
        if (q.ph == 8'(LEAD_CYC - 1)) begin
          n.ph = 8'h00;
          n.st = H_SHIFT;
        end
      end
      H_SHIFT: begin
        n.ph = q.ph + 8'h01;
        if (q.ph == 8'h00) begin
          n.mosi = q.tx[31];
          n.tx   = {q.tx[30:0], 1'b0};
        end
        // Capture just as the clock rises, before the device moves
        if (q.ph == 8'(HALF - 1)) begin
          n.sclk = 1'b1;
          n.rx   = rxb;
          if (q.op == rfifo_pkg::OP_FIFO) begin
            if (q.sts && q.bn == 14'h000F) begin
              n.sv     = 1'b1;
              n.status = rxb[7:0];
            end
            if (q.bn >= 14'(rfifo_pkg::CMD_BITS)) begin
              n.sc = q.sc + 6'h01;
              if (q.sc == slen - 6'h01) begin
                n.sc   = 6'h00;
                n.wv   = 1'b1;
                n.word = q.hdr ? rxb : {8'h00, rxb[23:0]};
              end
            end
          end else if (q.op == rfifo_pkg::OP_RREG &&
                       q.bn == q.last) begin
            n.rv    = 1'b1;
            n.rdata = rxb[23:0];
          end
        end
        if (q.ph == 8'(2 * HALF - 1)) begin
          n.sclk = 1'b0;
          n.ph   = 8'h00;
          n.bn   = q.bn + 14'h0001;
          if (q.bn == q.last) begin
            n.st   = H_TAIL;
            n.cs_n = 1'b1;
          end
        end
      end
      H_TAIL: begin
        n.ph   = q.ph + 8'h01;
        n.mosi = 1'b0;
        if (q.ph == 8'(HALF - 1)) begin
          n.st   = H_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
        end
      end
      default: begin
        n.st = H_IDLE;
      end
    endcase
  end

  // Host state register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q      <= '0;
      q.st   <= H_IDLE;
      q.cs_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign link.sclk      = q.sclk;
  assign link.cs_n      = q.cs_n;
  assign link.sdi       = q.mosi;
  assign o_busy         = q.busy;
  assign o_word_valid   = q.wv;
  assign o_word         = q.word;
  assign o_status_valid = q.sv;
  assign o_status       = q.status;
  assign o_rdata_valid  = q.rv;
  assign o_rdata        = q.rdata;
  assign o_done         = q.done;
  assign o_late         = q.late;

endmodule

`default_nettype wire

// ===== rfifo_monitor.sv
// Checker on the serial link joining the two buffer ends.
// Assumes the host paces sclk from the core clock.
`default_nettype none
module rfifo_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo
);
  logic        sclk_q;
  logic [13:0] nb_q;
  logic [7:0]  cmd_q;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Rises per frame; clearing lags cs_n so the end checks see the total
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_q <= 1'b0;
      nb_q   <= '0;
      cmd_q  <= '0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        nb_q <= '0;
      end else if (sclk && !sclk_q) begin
        nb_q <= nb_q + 14'h1;
        if (nb_q < 14'h8) cmd_q <= {cmd_q[6:0], sdi};
      end
    end
  end
  property p_sdo; cs_n |-> !sdo; endproperty
  a_sdo: assert property (p_sdo) else $error("sdo busy");
  property p_clk; cs_n |-> !sclk; endproperty
  a_clk: assert property (p_clk) else $error("sclk idle");
  property p_lead; $fell(cs_n) |-> !sclk [*8]; endproperty
  a_lead: assert property (p_lead) else $error("lead");
  property p_hi; $rose(sclk) |-> sclk [*3] ##1 !sclk; endproperty
  a_hi: assert property (p_hi) else $error("sclk high");
  property p_sdi; sclk |-> $stable(sdi); endproperty
  a_sdi: assert property (p_sdi) else $error("sdi moved");
  property p_cmd; $rose(cs_n) |-> cmd_q inside {8'h7D, 8'h7A, 8'h3A};
  endproperty
  a_cmd: assert property (p_cmd) else $error("command");
  property p_len; $rose(cs_n) |-> nb_q >= 14'h10 && nb_q[2:0] == 3'h0;
  endproperty
  a_len: assert property (p_len) else $error("length");
  property p_gap; $rose(cs_n) |-> cs_n [*3]; endproperty
  a_gap: assert property (p_gap) else $error("gap");
endmodule
`default_nettype wire

// ===== rfifo_pkg.sv
// Shared constants for the conversion result buffer and its serial link.
// Assumes both link ends and the bench refer to these by scoped name.
`default_nettype none

package rfifo_pkg;

  // ----------------------------------------------------------------
  // Buffer geometry and entry layout
  // ----------------------------------------------------------------
  localparam int          DEPTH         = 256;
  localparam int          HDR_EMPTY_BIT = 4;
  localparam int          HDR_WM_BIT    = 5;

  // ----------------------------------------------------------------
  // Register map and control fields
  // ----------------------------------------------------------------
  localparam logic [5:0]  ADDR_CTRL     = 6'h3A;
  localparam logic [5:0]  ADDR_FIFO     = 6'h3D;
  localparam logic [7:0]  CMD_RD_FLAG   = 8'h40;
  localparam logic [7:0]  CMD_FIFO_RD   = 8'h7D;
  localparam logic [7:0]  CMD_CTRL_RD   = 8'h7A;
  localparam logic [7:0]  CMD_CTRL_WR   = 8'h3A;
  localparam logic [23:0] CTRL_RST      = 24'h040200;
  localparam int          CTRL_WM_LSB   = 0;
  localparam int          CTRL_IRQ_LSB  = 8;
  localparam int          LOWER_LIMIT_IRQ_ENABLE_BIT = 11;
  localparam int          UPPER_LIMIT_IRQ_ENABLE_BIT = 12;
  localparam int          CTRL_MODE_LSB = 16;
  localparam int          CTRL_HDR_BIT  = 18;
  localparam int          CTRL_STS_BIT  = 19;
  localparam logic [1:0]  MODE_OFF      = 2'h0;
  localparam logic [1:0]  MODE_WM       = 2'h1;
  localparam logic [1:0]  MODE_STREAM   = 2'h2;

  // ----------------------------------------------------------------
  // Buffer status byte
  // ----------------------------------------------------------------
  localparam logic [7:0]  STS_RST       = 8'h01;
  localparam int          STS_EMPTY     = 0;
  localparam int          STS_WM        = 1;
  localparam int          STS_OVR       = 2;
  localparam int          STS_RERR      = 5;
  localparam int          STS_WERR      = 6;

  // ----------------------------------------------------------------
  // Frame timing in serial clocks, and host budget figures
  // ----------------------------------------------------------------
  localparam int          CMD_BITS      = 16;
  localparam int          SAMP_BITS_HDR = 32;
  localparam int          SAMP_BITS_RAW = 24;
  localparam int          REG_BITS      = 24;
  localparam int          BUSY_QUIET_MCLK = 8;
  localparam int          CORE_PERIOD_NS  = 40;

  // Host operations
  localparam logic [1:0]  OP_FIFO       = 2'h0;
  localparam logic [1:0]  OP_RREG       = 2'h1;
  localparam logic [1:0]  OP_WREG       = 2'h2;

endpackage

`default_nettype wire

// ===== spi_link_if.sv
// Four-wire serial link between buffer device and host controller.
// Assumes the host drives clock, select and data in; device drives out.
`default_nettype none

interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;

  modport dev  (input sclk, input cs_n, input sdi, output sdo);
  modport host (output sclk, output cs_n, output sdi, input sdo);
endinterface

`default_nettype wire

// ===== sync2.sv
// Two-stage synchroniser for levels and toggles, any width.
// Assumes each bit is a level or toggle that holds for several clocks.
`default_nettype none

module sync2 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= RST;
      o_q    <= RST;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule

`default_nettype wire

// ===== tb.sv
// Bench: both buffer ends on one link, checked against a queue model.
// Assumes package, interface, design and monitor compile first.
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, start, cv, sts, w_v, s_v, r_v, done, late;
  logic        own, busy, hd;
  logic [1:0]  op, md;
  logic [3:0]  ch;
  logic [7:0]  n8, st, s, dst;
  logic [8:0]  cnt;
  logic [23:0] cd, wd, r, rq, ctl;
  logic [31:0] w, rng = 32'hA3BEB8EB, mq[$], gq[$];
  int          n_fail = 0, n_tests = 0, lvl = 256;
  spi_link_if  lnk();
  conv_fifo_dev i_conv_fifo_dev (.i_core_clk(clk), .i_rst(rst),
    .i_conv_valid(cv), .i_conv_data(cd), .i_conv_chan(ch), .link(lnk),
    .o_own(own), .o_count(cnt), .o_status(dst), .o_ctrl(ctl));
  conv_fifo_host #(.BUDGET_CYC(60000)) i_conv_fifo_host (.i_core_clk(clk),
    .i_rst(rst), .i_start(start), .i_op(op), .i_count(n8), .i_wdata(wd),
    .i_hdr_en(hd), .i_sts_en(sts), .link(lnk), .o_busy(busy),
    .o_word_valid(w_v), .o_word(w), .o_status_valid(s_v), .o_status(s),
    .o_rdata_valid(r_v), .o_rdata(r), .o_done(done), .o_late(late));
  rfifo_monitor i_rfifo_monitor (.i_core_clk(clk), .i_rst(rst),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .sdi(lnk.sdi), .sdo(lnk.sdo));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Results stand one cycle; sampled mid-cycle to avoid edge races
  always @(negedge clk) begin
    if (w_v) gq.push_back(w);
    if (s_v) st = s;
    if (r_v) rq = r;
  end
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic test_done();
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One host operation, bounded wait for its end of frame
  task automatic act(input logic [1:0] o, input logic [7:0] n,
                     input logic [23:0] d);
    int k;
    op = o;
    n8 = n;
    wd = d;
    start = 1'b1;
    @(posedge clk) #1 start = 1'b0;
    for (k = 0; k < 60000 && !done; k++) @(posedge clk) #1;
    if (!done) begin
      n_fail++;
      test_done();
    end
    repeat (5) @(posedge clk) #1;
  endtask
  task automatic setc(input logic [1:0] m, input logic [7:0] l,
                      input logic e, input logic h);
    logic [23:0] v;
    v = {4'h0, e, h, m, 8'h00, l};
    md = m;
    hd = h;
    sts = e;
    lvl = (l == 8'h00) ? 256 : l;
    act(rfifo_pkg::OP_WREG, 8'h00, v);
    `CHK(ctl, v)
    if (m == 2'h0 || m == 2'h3) mq.delete();
  endtask
  // Back-to-back conversions; the model keeps or drops as the mode says
  task automatic push(input int n);
    logic [31:0] e;
    repeat (n) begin
      e = rnd() & 32'h0FFFFFFF;
      {ch, cd} = e[27:0];
      cv = 1'b1;
      if (md == 2'h2 && mq.size() == 256) void'(mq.pop_front());
      e[29] = (mq.size() + 1 >= lvl);
      if (md == 2'h2 || (md == 2'h1 && mq.size() < lvl)) mq.push_back(e);
      @(posedge clk) #1;
    end
    cv = 1'b0;
    repeat (3) @(posedge clk) #1;
  endtask
  task automatic rd(input int n);
    logic [31:0] x, y;
    gq.delete();
    act(rfifo_pkg::OP_FIFO, n[7:0], 24'h0);
    `CHK(gq.size(), n)
    `CHK(own, 1'b0)
    `CHK(busy, 1'b0)
    repeat (n) begin
      x = (mq.size() != 0) ? mq.pop_front() : 32'h10000000;
      if (mq.size() == 0) x[28] = 1'b1;
      if (!hd) x[31:24] = 8'h00;
      y = gq.pop_front();
      `CHK(y, x)
    end
    `CHK(late, 1'b0)
  endtask
  initial begin
    {start, cv, sts, hd, op, md, n8, wd, ch, cd} = '0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk) #1;
    act(rfifo_pkg::OP_RREG, 8'h00, 24'h0);
    `CHK(rq, rfifo_pkg::CTRL_RST)
    setc(2'h2, 8'h00, 1'b1, 1'b1);
    push(258);
    `CHK(cnt, 9'h100)
    `CHK(dst[2], 1'b1)
    rd(256);
    `CHK(st[2], 1'b1)
    `CHK(dst[0], 1'b1)
    setc(2'h1, 8'h02, 1'b0, 1'b1);
    push(3);
    `CHK(cnt, 9'h002)
    rd(3);
    setc(2'h3, 8'h00, 1'b0, 1'b1);
    push(1);
    `CHK(cnt, 9'h000)
    setc(2'h2, 8'h05, 1'b0, 1'b0);
    push(3);
    rd(2);
    setc(2'h0, 8'h05, 1'b0, 1'b1);
    `CHK(cnt, 9'h000)
    test_done();
  end
endmodule
`default_nettype wire
